// *** rtl/sgc_ctrl.sv ***
/*
  switch global control register, fundamental reset sequencing and the
  downstream device number check.
  assumes a simple word register port driven by the management slave on
  CLK_SYS, a boot strap pin from outside the clock domain, and an eeprom
  loader done level from logic on CLK_SYS.
*/
`timescale 1ns/1ps

// Summary of operation
// - halt bit keeps switch quasi-reset, management active
// - clearing halt bit starts normal switching
// - halt writes ignored after reset sequence ends
// - halt bit loads from sampled boot strap
// - unlock bit gates writes to lockable fields
// - unlock bit set during reset sequence
// - budget unlock gates power budget value writes
// - budget unlock bit writable only when unlocked
// - check mode two bits; three is reserved
// - mode zero blocks all nonzero-device ID packets to the downstream link bus
// - mode one blocks such configuration requests only
// - mode two forwards every packet
// - check mode resets zero, survives ordinary resets
module sgc_ctrl
  import sgc_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RESET_N,
  input wire logic CLK_EN,
  input wire logic HOT_RESET,
  input wire logic BOOT_HALT_PIN,
  input wire logic EEPROM_LOAD_DONE,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [SGC_ADDR_W-1:0] REG_ADDR,
  input wire logic [SGC_DATA_W-1:0] REG_WDATA,
  output logic [SGC_DATA_W-1:0] REG_RDATA,
  output logic REG_RVALID,
  output logic SWITCH_QUASI_RESET,
  output logic LOCKABLE_WRITE_ENABLE,
  output logic POWER_BUDGET_UNLOCK,
  output logic [1:0] DEVNUM_CHECK_MODE,
  input wire logic CHK_VALID,
  input wire logic CHK_ID_ROUTED,
  input wire logic CHK_IS_CFG,
  input wire logic CHK_DS_LINK_BUS,
  input wire logic [4:0] CHK_DEVNUM,
  output logic CHK_DONE,
  output logic CHK_BLOCK
);

  typedef struct packed
  {
    // strap synchroniser, only boot_s2 is read by the sequence
    logic boot_s1;
    logic boot_s2;
    logic [1:0] settle;
    sgc_state_e state;
    logic hold_in_quasi_reset;
    logic lockable_write_enable;
    logic power_budget_unlock;
    logic [1:0] downstream_devnum_check_mode;
    // register read pipe
    logic rd_pend;
    logic rd_mem;
    logic [SGC_DATA_W-1:0] rd_data;
    logic [SGC_DATA_W-1:0] rdata;
    logic rvalid;
    logic quasi;
    logic chk_done;
    logic chk_block;
  } sgc_top_s;

  sgc_top_s st_r;
  sgc_top_s st_nxt;

  sgc_pbdv_if pbdv ();

  // ---------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------
  function automatic logic sgc_is_pbdv(input logic [SGC_ADDR_W-1:0] a);
    logic [SGC_ADDR_W-1:0] top;
    top = a - SGC_PBDV_BASE_OFS;
    sgc_is_pbdv = (a >= SGC_PBDV_BASE_OFS) && (top[1:0] == 2'h0)
      && (top[SGC_ADDR_W-1:2] < SGC_PBDV_WORDS[SGC_ADDR_W-3:0]);
  endfunction

  function automatic logic [SGC_PBDV_IDX_W-1:0] sgc_pbdv_idx(input logic [SGC_ADDR_W-1:0] a);
    logic [SGC_ADDR_W-1:0] off;
    off = a - SGC_PBDV_BASE_OFS;
    sgc_pbdv_idx = off[SGC_PBDV_IDX_W+1:2];
  endfunction

  // control register select, shared by the write and the read path
  function automatic logic sgc_is_ctrl(input logic [SGC_ADDR_W-1:0] a);
    sgc_is_ctrl = (a == SGC_CTRL_OFS);
  endfunction

  // readback word; unlisted bit positions stay zero
  function automatic logic [SGC_DATA_W-1:0] sgc_ctrl_word(input sgc_top_s s);
    logic [SGC_DATA_W-1:0] w;
    w = '0;
    w[SGC_HALT_BIT] = s.hold_in_quasi_reset;
    w[SGC_UNLOCK_BIT] = s.lockable_write_enable;
    w[SGC_PBUL_BIT] = s.power_budget_unlock;
    w[SGC_MODE_MSB:SGC_MODE_LSB] = s.downstream_devnum_check_mode;
    sgc_ctrl_word = w;
  endfunction

  // block decision of the device number check
  function automatic logic sgc_block(input logic [1:0] mode, input logic id_routed,
                                     input logic is_cfg, input logic ds_bus,
                                     input logic [4:0] devnum);
    logic hit;
    hit = id_routed && ds_bus && (devnum != 5'h00);
    case (mode)
      SGC_MODE_ALL: sgc_block = hit;
      SGC_MODE_CFG: sgc_block = hit && is_cfg;
      SGC_MODE_NONE: sgc_block = 1'b0;
      // the reserved code is never stored; fall back to the strictest check
      default: sgc_block = hit;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // power budget store access
  // ---------------------------------------------------------------
  // the value store answers a read one edge after the request
  assign pbdv.wr = REG_WR && sgc_is_pbdv(REG_ADDR);
  assign pbdv.rd = REG_RD && sgc_is_pbdv(REG_ADDR);
  assign pbdv.idx = sgc_pbdv_idx(REG_ADDR);
  assign pbdv.wdata = REG_WDATA;
  assign pbdv.unlock = st_r.power_budget_unlock;

  sgc_pbdv_mem u_pbdv
  (
    .clk(CLK_SYS),
    .rst_n(RESET_N),
    .ce(CLK_EN),
    .bus(pbdv.mem)
  );

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    logic ctrl_hit;
    ctrl_hit = 1'b0;
    st_nxt = st_r;

    // boot strap synchroniser
    st_nxt.boot_s1 = BOOT_HALT_PIN;
    st_nxt.boot_s2 = st_r.boot_s1;

    // software write of the control register
    ctrl_hit = REG_WR && sgc_is_ctrl(REG_ADDR);
    if (ctrl_hit)
    begin
      // the halt bit only moves before the switch runs
      if (st_r.state != SGC_ST_RUN)
      begin
        st_nxt.hold_in_quasi_reset = REG_WDATA[SGC_HALT_BIT];
      end
      // a same-edge hardware set at the end of sampling wins over this write
      st_nxt.lockable_write_enable = REG_WDATA[SGC_UNLOCK_BIT];
      if (st_r.lockable_write_enable)
      begin
        st_nxt.power_budget_unlock = REG_WDATA[SGC_PBUL_BIT];
      end
      // the reserved encoding is refused and the old mode kept
      if (REG_WDATA[SGC_MODE_MSB:SGC_MODE_LSB] != SGC_MODE_RSVD)
      begin
        st_nxt.downstream_devnum_check_mode = REG_WDATA[SGC_MODE_MSB:SGC_MODE_LSB];
      end
    end

    // fundamental reset sequence
    case (st_r.state)
      SGC_ST_SAMPLE:
      begin
        if (st_r.settle == SGC_SETTLE_CYC)
        begin
          st_nxt.hold_in_quasi_reset = st_r.boot_s2;
          st_nxt.lockable_write_enable = 1'b1;
          st_nxt.state = SGC_ST_EELOAD;
        end
        else
        begin
          st_nxt.settle = st_r.settle + 2'h1;
        end
      end
      SGC_ST_EELOAD:
      begin
        if (EEPROM_LOAD_DONE)
        begin
          st_nxt.state = SGC_ST_HALT;
        end
      end
      SGC_ST_HALT:
      begin
        // a write that sets the halt bit on this edge keeps the switch held
        if (!st_nxt.hold_in_quasi_reset)
        begin
          st_nxt.state = SGC_ST_RUN;
        end
      end
      SGC_ST_RUN:
      begin
        st_nxt.state = SGC_ST_RUN;
      end
      default:
      begin
        st_nxt.state = SGC_ST_SAMPLE;
      end
    endcase

    // switch logic held quiet until the sequence reaches run
    st_nxt.quasi = (st_nxt.state != SGC_ST_RUN);

    // register read, answered two edges after the request
    st_nxt.rd_pend = REG_RD;
    st_nxt.rd_mem = REG_RD && sgc_is_pbdv(REG_ADDR);
    st_nxt.rd_data = '0;
    if (REG_RD && sgc_is_ctrl(REG_ADDR))
    begin
      st_nxt.rd_data = sgc_ctrl_word(st_r);
    end
    st_nxt.rvalid = st_r.rd_pend;
    st_nxt.rdata = '0;
    if (st_r.rd_pend)
    begin
      st_nxt.rdata = st_r.rd_mem ? pbdv.rdata : st_r.rd_data;
    end

    // device number check, only while switching
    st_nxt.chk_done = CHK_VALID && !st_r.quasi;
    st_nxt.chk_block = 1'b0;
    if (CHK_VALID && !st_r.quasi)
    begin
      st_nxt.chk_block = sgc_block(st_r.downstream_devnum_check_mode, CHK_ID_ROUTED,
                                   CHK_IS_CFG, CHK_DS_LINK_BUS, CHK_DEVNUM);
    end

    // an ordinary reset drops transient state; sticky fields stay
    if (HOT_RESET)
    begin
      st_nxt.rd_pend = 1'b0;
      st_nxt.rd_mem = 1'b0;
      st_nxt.rd_data = '0;
      st_nxt.rvalid = 1'b0;
      st_nxt.rdata = '0;
      st_nxt.chk_done = 1'b0;
      st_nxt.chk_block = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  // only the fundamental reset returns the sticky fields to their defaults
  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      st_r.boot_s1 <= 1'b0;
      st_r.boot_s2 <= 1'b0;
      st_r.settle <= 2'h0;
      st_r.state <= SGC_ST_SAMPLE;
      st_r.hold_in_quasi_reset <= SGC_HALT_RST;
      st_r.lockable_write_enable <= SGC_UNLOCK_RST;
      st_r.power_budget_unlock <= SGC_PBUL_RST;
      st_r.downstream_devnum_check_mode <= SGC_MODE_RST;
      st_r.rd_pend <= 1'b0;
      st_r.rd_mem <= 1'b0;
      st_r.rd_data <= '0;
      st_r.rdata <= '0;
      st_r.rvalid <= 1'b0;
      st_r.quasi <= 1'b1;
      st_r.chk_done <= 1'b0;
      st_r.chk_block <= 1'b0;
    end
    else if (CLK_EN)
    begin
      st_r <= st_nxt;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // every output is a flop of the registered state copy
  assign REG_RDATA = st_r.rdata;
  assign REG_RVALID = st_r.rvalid;
  assign SWITCH_QUASI_RESET = st_r.quasi;
  assign LOCKABLE_WRITE_ENABLE = st_r.lockable_write_enable;
  assign POWER_BUDGET_UNLOCK = st_r.power_budget_unlock;
  assign DEVNUM_CHECK_MODE = st_r.downstream_devnum_check_mode;
  assign CHK_DONE = st_r.chk_done;
  assign CHK_BLOCK = st_r.chk_block;

endmodule

// *** rtl/sgc_pbdv_if.sv ***
/*
  carrier between the control block and the power budget value store.
  assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface sgc_pbdv_if;
  import sgc_pkg::*;
  logic wr;
  logic rd;
  logic [SGC_PBDV_IDX_W-1:0] idx;
  logic [SGC_DATA_W-1:0] wdata;
  logic unlock;
  logic [SGC_DATA_W-1:0] rdata;

  modport ctrl (output wr, output rd, output idx, output wdata, output unlock, input rdata);
  modport mem (input wr, input rd, input idx, input wdata, input unlock, output rdata);
endinterface

// *** rtl/sgc_pbdv_mem.sv ***
/*
  store of the eight power budget data values, registered read data.
  assumes the control block drives the interface from its clock domain.
*/
`timescale 1ns/1ps
module sgc_pbdv_mem
  import sgc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  sgc_pbdv_if.mem bus
);

  typedef struct packed
  {
    logic [SGC_PBDV_WORDS-1:0][SGC_DATA_W-1:0] word;
    logic [SGC_DATA_W-1:0] rdata;
  } sgc_mem_s;

  sgc_mem_s mem_r;
  sgc_mem_s mem_nxt;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    mem_nxt = mem_r;
    if (bus.rd)
    begin
      mem_nxt.rdata = mem_r.word[bus.idx];
    end
    // values change only while the unlock bit is set
    if (bus.wr && bus.unlock)
    begin
      mem_nxt.word[bus.idx] = bus.wdata;
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mem_r.word <= {SGC_PBDV_WORDS{SGC_PBDV_RST}};
      mem_r.rdata <= '0;
    end
    else if (ce)
    begin
      mem_r <= mem_nxt;
    end
  end

  assign bus.rdata = mem_r.rdata;

endmodule

// *** rtl/sgc_pkg.sv ***
/*
  constants, field layout and state codes of the switch global control block.
  assumes a single 200 MHz system clock; no other package is needed.
*/
package sgc_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam int SGC_ADDR_W = 16;
  localparam int SGC_DATA_W = 32;
  localparam logic [15:0] SGC_CTRL_OFS = 16'h0000;
  localparam logic [15:0] SGC_PBDV_BASE_OFS = 16'h0100;
  localparam int SGC_PBDV_WORDS = 8;
  localparam int SGC_PBDV_IDX_W = 3;

  // ---------------------------------------------------------------
  // control register fields
  // ---------------------------------------------------------------
  localparam int SGC_HALT_BIT = 2;
  localparam int SGC_UNLOCK_BIT = 3;
  localparam int SGC_PBUL_BIT = 4;
  localparam int SGC_MODE_LSB = 9;
  localparam int SGC_MODE_MSB = 10;

  // ---------------------------------------------------------------
  // check mode encodings and reset values
  // ---------------------------------------------------------------
  localparam logic [1:0] SGC_MODE_ALL = 2'h0;
  localparam logic [1:0] SGC_MODE_CFG = 2'h1;
  localparam logic [1:0] SGC_MODE_NONE = 2'h2;
  localparam logic [1:0] SGC_MODE_RSVD = 2'h3;
  localparam logic [1:0] SGC_MODE_RST = 2'h0;
  localparam logic SGC_HALT_RST = 1'b0;
  localparam logic SGC_UNLOCK_RST = 1'b0;
  localparam logic SGC_PBUL_RST = 1'b0;
  localparam logic [31:0] SGC_PBDV_RST = 32'h0000_0000;

  // ---------------------------------------------------------------
  // timing: cycles given to the boot strap synchroniser to settle
  // ---------------------------------------------------------------
  localparam logic [1:0] SGC_SETTLE_CYC = 2'h3;

  // ---------------------------------------------------------------
  // fundamental reset sequence states
  // ---------------------------------------------------------------
  typedef enum logic [3:0]
  {
    SGC_ST_SAMPLE = 4'b0001,
    SGC_ST_EELOAD = 4'b0010,
    SGC_ST_HALT = 4'b0100,
    SGC_ST_RUN = 4'b1000
  } sgc_state_e;

endpackage

// *** sim/sgc_ctrl_checker.sv ***
/*
  concurrent checks on the ports of the switch global control block.
  assumes one clock and an async active-low reset; bound to sgc_ctrl.
*/
`timescale 1ns/1ps
module sgc_ctrl_checker
  import sgc_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RESET_N,
  input wire logic CLK_EN,
  input wire logic HOT_RESET,
  input wire logic REG_RD,
  input wire logic REG_WR,
  input wire logic [SGC_DATA_W-1:0] REG_RDATA,
  input wire logic REG_RVALID,
  input wire logic SWITCH_QUASI_RESET,
  input wire logic LOCKABLE_WRITE_ENABLE,
  input wire logic POWER_BUDGET_UNLOCK,
  input wire logic [1:0] DEVNUM_CHECK_MODE,
  input wire logic CHK_VALID,
  input wire logic CHK_ID_ROUTED,
  input wire logic CHK_IS_CFG,
  input wire logic CHK_DS_LINK_BUS,
  input wire logic [4:0] CHK_DEVNUM,
  input wire logic CHK_DONE,
  input wire logic CHK_BLOCK
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RESET_N);
  wire hit = CHK_ID_ROUTED & CHK_DS_LINK_BUS & (CHK_DEVNUM != 5'h00);
  wire take = CHK_VALID & CLK_EN & ~SWITCH_QUASI_RESET & ~HOT_RESET;
  sequence s_rd_req;
    REG_RD && CLK_EN && !HOT_RESET ##1 CLK_EN && !HOT_RESET;
  endsequence
  sequence s_chk(logic [1:0] m);
    take && DEVNUM_CHECK_MODE == m;
  endsequence
  AST_RD_LAT: assert property (s_rd_req |-> ##[1:2] REG_RVALID)
    else $error("read answer missing");
  AST_RDATA_IDLE: assert property (!REG_RVALID |-> REG_RDATA == 32'h0000_0000)
    else $error("read data not zero when idle");
  AST_QR_NO_CHK: assert property (CHK_VALID && SWITCH_QUASI_RESET |=> !CHK_DONE)
    else $error("check answered while held");
  AST_RUN_STAYS: assert property (!SWITCH_QUASI_RESET |=> !SWITCH_QUASI_RESET)
    else $error("switch halted again after run");
  AST_UNLOCK_SET: assert property ($rose(RESET_N) |-> ##[1:8] LOCKABLE_WRITE_ENABLE)
    else $error("unlock not set by reset sequence");
  AST_PBUL_LOCKED: assert property (!LOCKABLE_WRITE_ENABLE |=> $stable(POWER_BUDGET_UNLOCK))
    else $error("budget unlock changed while locked");
  AST_MODE_LEGAL: assert property (DEVNUM_CHECK_MODE != 2'h3)
    else $error("reserved check mode");
  AST_MODE0: assert property (s_chk(2'h0) |=> CHK_DONE && CHK_BLOCK == $past(hit))
    else $error("mode 0 verdict");
  AST_MODE1: assert property (s_chk(2'h1) |=> CHK_BLOCK == $past(hit && CHK_IS_CFG))
    else $error("mode 1 verdict");
  AST_MODE2: assert property (s_chk(2'h2) |=> CHK_DONE && !CHK_BLOCK)
    else $error("mode 2 verdict");
  AST_HOT_KEEP: assert property (HOT_RESET && !REG_WR |=> $stable(DEVNUM_CHECK_MODE))
    else $error("check mode lost on ordinary reset");
endmodule

bind sgc_ctrl sgc_ctrl_checker chk (.*);

// *** sim/tb_top.sv ***
/*
  self-checking bench for the switch global control block.
  assumes sgc_ctrl and its checker are compiled first; random seed fixed.
*/
`timescale 1ns/1ps
module tb_top
  import sgc_pkg::*;
;
  logic CLK_SYS = 0, RESET_N = 0, CLK_EN = 1, HOT_RESET = 0, BOOT_HALT_PIN = 1;
  logic EEPROM_LOAD_DONE = 0, REG_WR = 0, REG_RD = 0, CHK_VALID = 0;
  logic CHK_ID_ROUTED = 0, CHK_IS_CFG = 0, CHK_DS_LINK_BUS = 0;
  logic [4:0] CHK_DEVNUM = 5'h00;
  logic [15:0] REG_ADDR = 16'h0000;
  logic [31:0] REG_WDATA = 32'h0000_0000;
  logic [31:0] REG_RDATA, rv, bv;
  logic REG_RVALID, SWITCH_QUASI_RESET, LOCKABLE_WRITE_ENABLE, POWER_BUDGET_UNLOCK;
  logic [1:0] DEVNUM_CHECK_MODE, md;
  logic CHK_DONE, CHK_BLOCK;
  logic [7:0] r;
  int errors = 0, cmp_count = 0;

  sgc_ctrl dut (.*);

  initial forever #2.5 CLK_SYS = ~CLK_SYS;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk_w(input logic [31:0] got, input logic [31:0] exp, input string msg);
    cmp_count++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic chk_v(input logic [1:0] got, input logic [1:0] exp);
    chk_w({30'h0, got}, {30'h0, exp}, "check verdict");
  endtask
  task automatic tick();
    @(posedge CLK_SYS);
    #1;
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    tick();
    {REG_WR, REG_ADDR, REG_WDATA} = {1'b1, a, d};
    tick();
    REG_WR = 0;
  endtask
  task automatic rd(input logic [15:0] a, output logic [31:0] d);
    tick();
    {REG_RD, REG_ADDR} = {1'b1, a};
    tick();
    REG_RD = 0;
    for (int i = 0; i < 5 && REG_RVALID !== 1'b1; i++) tick();
    d = (REG_RVALID === 1'b1) ? REG_RDATA : 32'hBAD0_BAD0;
  endtask
  task automatic pkt(input logic [7:0] a);
    tick();
    {CHK_VALID, CHK_ID_ROUTED, CHK_IS_CFG, CHK_DS_LINK_BUS, CHK_DEVNUM} = {1'b1, a};
    tick();
    CHK_VALID = 0;
  endtask
  function automatic logic [31:0] cw(logic h, logic u, logic p, logic [1:0] m);
    return {21'h0, m, 4'h0, p, u, h, 2'h0};
  endfunction
  function automatic logic blk(logic [1:0] m, logic [7:0] a);
    logic hit;
    hit = a[7] & a[5] & (a[4:0] != 5'h00);
    return (m == 2'h0) ? hit : ((m == 2'h1) ? (hit & a[6]) : 1'b0);
  endfunction

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    void'($urandom(79));
    repeat (16) @(posedge CLK_SYS);
    #1;
    RESET_N = 1;
    repeat (8) tick();
    chk_w({31'h0, SWITCH_QUASI_RESET}, 32'h1, "held");
    pkt(8'hFF);
    chk_v({CHK_DONE, CHK_BLOCK}, 2'h0);
    rd(16'h0000, rv);
    chk_w(rv, cw(1, 1, 0, 2'h0), "boot ctrl");
    wr(16'h0000, 32'hFFFF_FBFF);
    rd(16'h0000, rv);
    chk_w(rv, cw(1, 1, 1, 2'h1), "reserved");
    wr(16'h0000, cw(1, 1, 1, 2'h3));
    chk_w({30'h0, DEVNUM_CHECK_MODE}, 32'h1, "mode 3");
    bv = $urandom;
    wr(16'h0104, bv);
    rd(16'h0104, rv);
    chk_w(rv, bv, "budget open");
    wr(16'h0000, cw(1, 1, 0, 2'h1));
    wr(16'h0104, ~bv);
    rd(16'h0104, rv);
    chk_w(rv, bv, "budget shut");
    wr(16'h0000, cw(1, 0, 0, 2'h1));
    wr(16'h0000, cw(1, 0, 1, 2'h1));
    chk_w({31'h0, POWER_BUDGET_UNLOCK}, 32'h0, "locked");
    rd(16'h0200, rv);
    chk_w(rv, 32'h0000_0000, "unmapped");
    EEPROM_LOAD_DONE = 1;
    wr(16'h0000, cw(0, 0, 0, 2'h1));
    repeat (4) tick();
    chk_w({31'h0, SWITCH_QUASI_RESET}, 32'h0, "run");
    wr(16'h0000, cw(1, 0, 0, 2'h1));
    rd(16'h0000, rv);
    chk_w(rv, cw(0, 0, 0, 2'h1), "late halt");
    HOT_RESET = 1;
    tick();
    HOT_RESET = 0;
    chk_w({30'h0, DEVNUM_CHECK_MODE}, 32'h1, "hot");
    // with the clock enable low a write must leave every field frozen
    CLK_EN = 0;
    wr(16'h0000, cw(0, 0, 0, 2'h2));
    chk_w({30'h0, DEVNUM_CHECK_MODE}, 32'h1, "frozen");
    CLK_EN = 1;
    for (int m = 0; m < 3; m++)
    begin
      md = m[1:0];
      wr(16'h0000, cw(0, 0, 0, md));
      repeat (40)
      begin
        r = 8'($urandom);
        // half the packets carry device number zero or one
        if (r[6])
          r[4:1] = 4'h0;
        pkt(r);
        chk_v({CHK_DONE, CHK_BLOCK}, {1'b1, blk(md, r)});
      end
    end
    give_verdict();
  end

  // about 320 cycles are expected; cut off well beyond that
  initial
  begin
    #20000;
    errors++;
    give_verdict();
  end
endmodule
